// file: charger_mode_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "charger_cfg.svh"
module charger_mode_control
  import charger_pkg::*;
#(
  parameter bit AUTO_CHARGE = 1'b1,
  parameter int unsigned TICK_CYCLES = `CHG_TICK_TIME_S * `CHG_CLK_HZ,
  parameter int unsigned RAMP_CYCLES = `CHG_RAMP_STEP_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic regWrite,
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  input wire logic porPulse,
  input wire logic disable_input,
  input wire logic chargeInhibit,
  input wire logic high_impedance_request,
  input wire logic prodTestRequest,
  input wire logic boostRequest,
  input wire logic batBelowShort,
  input wire logic batBelowPathExit,
  input wire logic batBelowWeak,
  input wire logic batBelowRecharge,
  input wire logic batAtFloat,
  input wire logic currentAtTerm,
  input wire logic junctionHot,
  input wire logic vbusNearFloor,
  input wire logic systemRailLow,
  output logic chargerOn,
  output logic boostOn,
  output logic pathBlocked,
  output logic linearSource,
  output logic pwmOn,
  output logic [3:0] chargeCurrentStep,
  output logic thermalReduce,
  output logic inputFoldback,
  output logic linearCurrentDown,
  output logic [12:0] float_voltage,
  output logic [11:0] testLoadLimitMa,
  output logic [1:0] input_current_limit_code,
  output logic [1:0] weak_battery_threshold,
  output logic [2:0] termination_current,
  output logic termination_enable,
  output logic chargeDone,
  output logic timerFault
);
  if (RAMP_CYCLES < 1 || RAMP_CYCLES > 65535) begin : g_bad_ramp
    $error("RAMP_CYCLES out of range");
  end

  // ----------------------------------------------------------------
  // Parameter registers
  // ----------------------------------------------------------------
  reg_byte_t reg1_r, reg2_r, reg4_r;
  timer_if tif();

  charge_timers #(.TICK_CYCLES(TICK_CYCLES)) timers (
    .ref_clk(ref_clk),
    .rst(rst),
    .tif(tif)
  );

  function automatic logic [12:0] floatMv(input logic [5:0] code);
    logic [5:0] sat;
    sat = (code > `CHG_FLOAT_SAT_CODE) ? `CHG_FLOAT_SAT_CODE : code;
    return `CHG_FLOAT_BASE_MV + 13'(sat) * `CHG_FLOAT_STEP_MV;
  endfunction

  assign tif.wrPulse = regWrite;
  assign tif.tmrReset = regWrite && regAddr == `CHG_REG_CTRL && regWrData[`CHG_TMR_RESET_BIT];

  // Watchdog expiry returns the parameters to their defaults.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg1_r <= `CHG_REG1_RST;
      reg2_r <= `CHG_REG2_RST;
      reg4_r <= `CHG_REG4_RST;
    end else if (tif.wdExpired) begin
      reg1_r <= `CHG_REG1_RST;
      reg2_r <= `CHG_REG2_RST;
      reg4_r <= `CHG_REG4_RST;
    end else if (regWrite) begin
      if (regAddr == `CHG_REG_LIMITS) reg1_r <= regWrData;
      else if (regAddr == `CHG_REG_FLOAT) reg2_r <= regWrData;
      else if (regAddr == `CHG_REG_CURRENT) reg4_r <= regWrData;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) regRdData <= 8'h00;
    else if (regAddr == `CHG_REG_LIMITS) regRdData <= reg1_r;
    else if (regAddr == `CHG_REG_FLOAT) regRdData <= reg2_r;
    else if (regAddr == `CHG_REG_CURRENT) regRdData <= reg4_r;
    else regRdData <= 8'h00;
  end

  // ----------------------------------------------------------------
  // Mode and charge phase sequencing
  // ----------------------------------------------------------------
  chg_state_e state_r;
  logic enableOk, startReq, charging;
  logic [3:0] chgCode;

  assign chgCode = reg4_r[`CHG_ICHG_MSB:`CHG_ICHG_LSB];
  assign enableOk = !disable_input && !chargeInhibit && !high_impedance_request;
  assign startReq = enableOk && ((state_r == ST_DONE && batBelowRecharge)
                    || regWrite
                    || tif.wdExpired
                    || (AUTO_CHARGE && porPulse && batBelowWeak));
  assign charging = state_r == ST_PRE || state_r == ST_CC || state_r == ST_CV;
  assign tif.chargeActive = charging;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) state_r <= ST_IDLE;
    else if (high_impedance_request) state_r <= ST_HIZ;
    else if (prodTestRequest) state_r <= ST_PTEST;
    else if (boostRequest) state_r <= ST_BOOST;
    else if (!enableOk) state_r <= ST_IDLE;
    else if (startReq) state_r <= ST_PRE;
    else begin
      case (state_r)
        ST_HIZ, ST_PTEST, ST_BOOST: state_r <= ST_IDLE;
        ST_PRE: if (!batBelowShort) state_r <= ST_CC;
        ST_CC: if (tif.safetyExpired) state_r <= ST_FAULT;
          else if (batAtFloat) state_r <= ST_CV;
        ST_CV: if (tif.safetyExpired) state_r <= ST_FAULT;
          else if (reg1_r[`CHG_TE_BIT] && currentAtTerm) state_r <= ST_DONE;
        default: state_r <= state_r;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Current ramp and thermal fold-back
  // ----------------------------------------------------------------
  logic [15:0] rampCnt_r;
  logic [3:0] level_r;
  logic stepNow;

  // The ramp steps slowly so the current loop never overshoots on start.
  assign stepNow = rampCnt_r == 16'(RAMP_CYCLES - 1);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) rampCnt_r <= 16'h0;
    else if (state_r != ST_CC && state_r != ST_CV) rampCnt_r <= 16'h0;
    else if (stepNow) rampCnt_r <= 16'h0;
    else rampCnt_r <= rampCnt_r + 16'h1;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) level_r <= 4'h0;
    else if (state_r != ST_CC && state_r != ST_CV) level_r <= 4'h0;
    else if (stepNow && junctionHot && level_r != 4'h0) level_r <= level_r - 4'h1;
    else if (stepNow && !junctionHot && level_r < chgCode) level_r <= level_r + 4'h1;
    else if (level_r > chgCode) level_r <= chgCode;
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      chargerOn <= 1'b0;
      boostOn <= 1'b0;
      pathBlocked <= 1'b0;
      linearSource <= 1'b0;
      pwmOn <= 1'b0;
      chargeDone <= 1'b0;
      timerFault <= 1'b0;
    end else begin
      chargerOn <= charging || state_r == ST_PTEST;
      boostOn <= state_r == ST_BOOST;
      pathBlocked <= state_r == ST_HIZ;
      linearSource <= state_r == ST_PRE || (charging && batBelowPathExit);
      pwmOn <= state_r == ST_CC || state_r == ST_CV || state_r == ST_PTEST;
      chargeDone <= state_r == ST_DONE;
      timerFault <= state_r == ST_FAULT;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      chargeCurrentStep <= 4'h0;
      thermalReduce <= 1'b0;
      inputFoldback <= 1'b0;
      linearCurrentDown <= 1'b0;
    end else begin
      chargeCurrentStep <= level_r;
      thermalReduce <= charging && junctionHot;
      inputFoldback <= charging && vbusNearFloor;
      linearCurrentDown <= charging && batBelowPathExit && systemRailLow;
    end
  end

  // Production test overrides the programmed float voltage.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      float_voltage <= `CHG_FLOAT_BASE_MV;
      testLoadLimitMa <= 12'h000;
      input_current_limit_code <= 2'h0;
      weak_battery_threshold <= 2'h0;
      termination_current <= 3'h0;
      termination_enable <= 1'b0;
    end else begin
      float_voltage <= (state_r == ST_PTEST) ? `CHG_PTEST_MV
                       : floatMv(reg2_r[`CHG_FLOAT_MSB:`CHG_FLOAT_LSB]);
      testLoadLimitMa <= (state_r == ST_PTEST) ? `CHG_PTEST_MA : 12'h000;
      input_current_limit_code <= reg1_r[`CHG_INLIM_MSB:`CHG_INLIM_LSB];
      weak_battery_threshold <= reg1_r[`CHG_WEAK_MSB:`CHG_WEAK_LSB];
      termination_current <= reg4_r[`CHG_TERMINATION_CURRENT_MSB:`CHG_TERMINATION_CURRENT_LSB];
      termination_enable <= reg1_r[`CHG_TE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_hiz_req;
    high_impedance_request ##1 high_impedance_request;
  endsequence
  property p_hiz_off;
    @(posedge ref_clk) disable iff (rst) s_hiz_req |=> !chargerOn && !boostOn && pathBlocked;
  endproperty
  a_hiz_off: assert property (p_hiz_off) else $error("converters on in high impedance");

  property p_ptest;
    @(posedge ref_clk) disable iff (rst)
      !high_impedance_request && prodTestRequest |=> ##1
        float_voltage == 13'h1068 && testLoadLimitMa == 12'h8FC;
  endproperty
  a_ptest: assert property (p_ptest) else $error("test mode set points wrong");

  property p_float_decode;
    @(posedge ref_clk) disable iff (rst)
      state_r != ST_PTEST |=> float_voltage == 13'h0DAC
        + 13'($past(reg2_r[7:2]) > 6'h2F ? 6'h2F : $past(reg2_r[7:2])) * 13'h0014;
  endproperty
  a_float_decode: assert property (p_float_decode) else $error("float decode wrong");

  property p_term;
    @(posedge ref_clk) disable iff (rst)
      state_r == ST_CV && enableOk && !startReq && !prodTestRequest && !boostRequest
        && !tif.safetyExpired && currentAtTerm |=> (state_r == ST_DONE) == reg1_r[3];
  endproperty
  a_term: assert property (p_term) else $error("termination decision wrong");

  property p_no_term;
    @(posedge ref_clk) disable iff (rst) state_r == ST_CV && !reg1_r[3] |=> state_r != ST_DONE;
  endproperty
  a_no_term: assert property (p_no_term) else $error("terminated with TE clear");

  sequence s_pre_exit;
    state_r == ST_PRE ##1 state_r == ST_CC;
  endsequence
  property p_pre_exit;
    @(posedge ref_clk) disable iff (rst) s_pre_exit |-> $past(!batBelowShort) ##1 pwmOn;
  endproperty
  a_pre_exit: assert property (p_pre_exit) else $error("PWM start without short exit");

  property p_ramp;
    @(posedge ref_clk) disable iff (rst)
      state_r == ST_CC |=> {1'b0, level_r} <= {1'b0, $past(level_r)} + 5'h01;
  endproperty
  a_ramp: assert property (p_ramp) else $error("ramp step too large");

  property p_hot;
    @(posedge ref_clk) disable iff (rst)
      (state_r == ST_CC || state_r == ST_CV) && junctionHot |=> level_r <= $past(level_r);
  endproperty
  a_hot: assert property (p_hot) else $error("current rose while hot");

  property p_restart;
    @(posedge ref_clk) disable iff (rst)
      regWrite && enableOk && !prodTestRequest && !boostRequest |=> state_r == ST_PRE;
  endproperty
  a_restart: assert property (p_restart) else $error("write did not restart charge");

  property p_recharge;
    @(posedge ref_clk) disable iff (rst)
      state_r == ST_DONE && batBelowRecharge && enableOk && !prodTestRequest
        && !boostRequest |=> state_r == ST_PRE;
  endproperty
  a_recharge: assert property (p_recharge) else $error("recharge missed");
endmodule // charger_mode_control
`default_nettype wire

// file: charger_cfg.svh
`ifndef CHARGER_CFG_SVH
`define CHARGER_CFG_SVH

// ----------------------------------------------------------------
// Register indices and field positions
// ----------------------------------------------------------------
`define CHG_REG_CTRL 3'h0
`define CHG_REG_LIMITS 3'h1
`define CHG_REG_FLOAT 3'h2
`define CHG_REG_CURRENT 3'h4
`define CHG_TMR_RESET_BIT 7
`define CHG_INLIM_MSB 7
`define CHG_INLIM_LSB 6
`define CHG_WEAK_MSB 5
`define CHG_WEAK_LSB 4
`define CHG_TE_BIT 3
`define CHG_FLOAT_MSB 7
`define CHG_FLOAT_LSB 2
`define CHG_ICHG_MSB 6
`define CHG_ICHG_LSB 3
`define CHG_TERMINATION_CURRENT_MSB 2
`define CHG_TERMINATION_CURRENT_LSB 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CHG_REG1_RST 8'h08
`define CHG_REG2_RST 8'h00
`define CHG_REG4_RST 8'h00

// ----------------------------------------------------------------
// Analog set points
// ----------------------------------------------------------------
`define CHG_FLOAT_BASE_MV 13'h0DAC
`define CHG_FLOAT_STEP_MV 13'h0014
`define CHG_FLOAT_SAT_CODE 6'h2F
`define CHG_PTEST_MV 13'h1068
`define CHG_PTEST_MA 12'h8FC

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CHG_CLK_HZ 10000000
`define CHG_TICK_TIME_S 1
`define CHG_WD_TIME_S 32
`define CHG_SAFETY_TIME_S 900
`define CHG_RAMP_STEP_US 10
`define CHG_RAMP_STEP_CYCLES ((`CHG_RAMP_STEP_US * `CHG_CLK_HZ) / 1000000)

`endif

// file: charger_pkg.sv
package charger_pkg;
  typedef enum logic [3:0] {
    ST_IDLE, ST_HIZ, ST_PTEST, ST_BOOST, ST_PRE, ST_CC, ST_CV, ST_DONE, ST_FAULT
  } chg_state_e;
  typedef logic [7:0] reg_byte_t;
endpackage

// file: timer_if.sv
`timescale 1ns/1ps
`default_nettype none
interface timer_if;
  logic wrPulse;
  logic tmrReset;
  logic chargeActive;
  logic wdRunning;
  logic wdExpired;
  logic safetyExpired;
  modport ctrl(output wrPulse, output tmrReset, output chargeActive,
               input wdRunning, input wdExpired, input safetyExpired);
  modport tmr(input wrPulse, input tmrReset, input chargeActive,
              output wdRunning, output wdExpired, output safetyExpired);
endinterface
`default_nettype wire

// file: charge_timers.sv
`timescale 1ns/1ps
`default_nettype none
`include "charger_cfg.svh"
module charge_timers #(
  parameter int unsigned TICK_CYCLES = `CHG_TICK_TIME_S * `CHG_CLK_HZ
) (
  input wire logic ref_clk,
  input wire logic rst,
  timer_if.tmr tif
);
  if (TICK_CYCLES < 1) begin : g_bad_tick
    $error("TICK_CYCLES must be at least one");
  end

  logic [31:0] tick_r;
  logic [5:0] wdSec_r;
  logic [9:0] safeSec_r;
  logic running_r;
  logic safeEn;
  logic tick;

  assign tick = (tick_r == 32'(TICK_CYCLES - 1));
  assign safeEn = tif.chargeActive && !running_r;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) tick_r <= 32'h0;
    else if (tif.wrPulse || tick) tick_r <= 32'h0;
    else tick_r <= tick_r + 32'h1;
  end

  // Host watchdog: any write starts it, the reset bit restarts it.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      running_r <= 1'b0;
      wdSec_r <= 6'h0;
    end else if (tif.wrPulse || tif.tmrReset) begin
      running_r <= 1'b1;
      wdSec_r <= 6'h0;
    end else if (running_r && tick) begin
      if (wdSec_r == 6'(`CHG_WD_TIME_S - 1)) running_r <= 1'b0;
      wdSec_r <= wdSec_r + 6'h1;
    end
  end

  // Unattended timer runs only while charging without the host watchdog.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) safeSec_r <= 10'h0;
    else if (tif.wrPulse || !safeEn) safeSec_r <= 10'h0;
    else if (tick && safeSec_r != 10'(`CHG_SAFETY_TIME_S)) safeSec_r <= safeSec_r + 10'h1;
  end

  assign tif.wdRunning = running_r;
  assign tif.wdExpired = running_r && tick && wdSec_r == 6'(`CHG_WD_TIME_S - 1);
  assign tif.safetyExpired = safeSec_r == 10'(`CHG_SAFETY_TIME_S);

  property p_wr_starts_wd;
    @(posedge ref_clk) disable iff (rst) tif.wrPulse |=> running_r && wdSec_r == 6'h0;
  endproperty
  a_wr_starts_wd: assert property (p_wr_starts_wd) else $error("write did not start watchdog");

  property p_wr_clears_safety;
    @(posedge ref_clk) disable iff (rst) tif.wrPulse |=> safeSec_r == 10'h0;
  endproperty
  a_wr_clears_safety: assert property (p_wr_clears_safety) else $error("write kept safety count");
endmodule // charge_timers
`default_nettype wire

// file: host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic ref_clk,
  output logic regWrite,
  output logic [2:0] regAddr,
  output logic [7:0] regWrData,
  input wire logic [7:0] regRdData
);
  initial begin
    regWrite = 1'b0;
    regAddr = 3'h0;
    regWrData = 8'h00;
  end

  // ----------------------------------------------------------------
  // Register access
  // ----------------------------------------------------------------
  // The released data bus shows the inverse of the last byte, so that
  // stale data can never pass for a fresh write.
  task automatic write_reg(input logic [2:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    regWrite = 1'b1;
    regAddr = a;
    regWrData = d;
    @(negedge ref_clk);
    regWrite = 1'b0;
    regWrData = ~d;
  endtask

  task automatic read_reg(input logic [2:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    regAddr = a;
    @(negedge ref_clk);
    d = regRdData;
  endtask
endmodule // host_model
`default_nettype wire

// file: charger_mode_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module charger_mode_control_tb;
  import charger_pkg::*;
  logic ref_clk, rst, porPulse, disable_input, chargeInhibit, high_impedance_request;
  logic prodTestRequest, boostRequest, batBelowShort, batBelowPathExit, batBelowWeak;
  logic batBelowRecharge, batAtFloat, currentAtTerm, junctionHot, vbusNearFloor, systemRailLow;
  logic regWrite, chargerOn, boostOn, pathBlocked, linearSource, pwmOn, thermalReduce;
  logic inputFoldback, linearCurrentDown, termination_enable, chargeDone, timerFault;
  logic [2:0] regAddr, termination_current;
  logic [7:0] regWrData, regRdData;
  logic [3:0] chargeCurrentStep, prevStep;
  logic [12:0] float_voltage;
  logic [11:0] testLoadLimitMa;
  logic [1:0] input_current_limit_code, weak_battery_threshold;
  logic [5:0] codes [6] = '{6'h00, 6'h01, 6'h23, 6'h2E, 6'h2F, 6'h3F};
  int n_errors = 0;
  int comparisons = 0;

  charger_mode_control #(.AUTO_CHARGE(1'b1), .TICK_CYCLES(10), .RAMP_CYCLES(4))
    charger_mode_control_inst (
    .ref_clk(ref_clk),
    .rst(rst),
    .regWrite(regWrite),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regRdData(regRdData),
    .porPulse(porPulse),
    .disable_input(disable_input),
    .chargeInhibit(chargeInhibit),
    .high_impedance_request(high_impedance_request),
    .prodTestRequest(prodTestRequest),
    .boostRequest(boostRequest),
    .batBelowShort(batBelowShort),
    .batBelowPathExit(batBelowPathExit),
    .batBelowWeak(batBelowWeak),
    .batBelowRecharge(batBelowRecharge),
    .batAtFloat(batAtFloat),
    .currentAtTerm(currentAtTerm),
    .junctionHot(junctionHot),
    .vbusNearFloor(vbusNearFloor),
    .systemRailLow(systemRailLow),
    .chargerOn(chargerOn),
    .boostOn(boostOn),
    .pathBlocked(pathBlocked),
    .linearSource(linearSource),
    .pwmOn(pwmOn),
    .chargeCurrentStep(chargeCurrentStep),
    .thermalReduce(thermalReduce),
    .inputFoldback(inputFoldback),
    .linearCurrentDown(linearCurrentDown),
    .float_voltage(float_voltage),
    .testLoadLimitMa(testLoadLimitMa),
    .input_current_limit_code(input_current_limit_code),
    .weak_battery_threshold(weak_battery_threshold),
    .termination_current(termination_current),
    .termination_enable(termination_enable),
    .chargeDone(chargeDone),
    .timerFault(timerFault)
  );
  host_model host_model_inst (.ref_clk(ref_clk), .regWrite(regWrite), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData));

  initial ref_clk = 1'b0;
  always #50 ref_clk = ~ref_clk;

  // ----------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------
  task automatic chkb(input string nm, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %b seen %b", nm, exp, got);
    end
  endtask

  task automatic chkv(input string nm, input logic [12:0] exp, input logic [12:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic rdchk(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host_model_inst.read_reg(a, d);
    chkv("regRdData", {5'h00, exp}, {5'h00, d});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  function automatic logic [12:0] floatExp(input logic [5:0] c);
    return (c >= 6'h2F) ? 13'h1158 : 13'h0DAC + 13'h0014 * {7'h00, c};
  endfunction

  task results;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // The whole run is about 10000 cycles; twice that means a hang.
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    results();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst, porPulse, disable_input, chargeInhibit, high_impedance_request} = 5'h10;
    {prodTestRequest, boostRequest, batBelowShort, batBelowPathExit, batBelowWeak} = 5'h00;
    {batBelowRecharge, batAtFloat, currentAtTerm, junctionHot} = 4'h0;
    {vbusNearFloor, systemRailLow} = 2'h0;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    chkv("floatReset", 13'h0DAC, float_voltage);
    rst = 1'b0;
    cyc(2);
    chkb("termEnable", 1'b1, termination_enable);
    rdchk(3'h1, 8'h08);
    rdchk(3'h2, 8'h00);
    rdchk(3'h4, 8'h00);
    rdchk(3'h3, 8'h00);
    rdchk(3'h0, 8'h00);
    porPulse = 1'b1;
    cyc(1);
    porPulse = 1'b0;
    cyc(3);
    chkb("chargerOn", 1'b0, chargerOn);
    {porPulse, batBelowWeak, batBelowShort} = 3'h7;
    cyc(1);
    {porPulse, batBelowWeak} = 2'h0;
    cyc(3);
    chkb("chargerOn", 1'b1, chargerOn);
    chkb("linearSource", 1'b1, linearSource);
    chkb("pwmOn", 1'b0, pwmOn);
    host_model_inst.write_reg(3'h4, 8'h28);
    cyc(3);
    rdchk(3'h4, 8'h28);
    chkb("linearSource", 1'b1, linearSource);
    batBelowShort = 1'b0;
    prevStep = 4'h0;
    for (int i = 0; i < 40; i++) begin
      cyc(1);
      chkb("rampSlew", 1'b1, chargeCurrentStep <= prevStep + 4'h1);
      prevStep = chargeCurrentStep;
    end
    chkv("rampEnd", 13'h0005, {9'h000, chargeCurrentStep});
    chkb("pwmOn", 1'b1, pwmOn);
    chkb("linearSource", 1'b0, linearSource);
    {junctionHot, vbusNearFloor, batBelowPathExit, systemRailLow} = 4'hF;
    cyc(3);
    chkb("thermalReduce", 1'b1, thermalReduce);
    chkb("inputFoldback", 1'b1, inputFoldback);
    chkb("linearCurrentDown", 1'b1, linearCurrentDown);
    chkb("linearSource", 1'b1, linearSource);
    cyc(12);
    chkb("thermalCut", 1'b1, chargeCurrentStep < 4'h5);
    {junctionHot, vbusNearFloor, batBelowPathExit, systemRailLow} = 4'h0;
    cyc(3);
    chkb("thermalReduce", 1'b0, thermalReduce);
    chkb("inputFoldback", 1'b0, inputFoldback);
    chkb("linearCurrentDown", 1'b0, linearCurrentDown);
    {batAtFloat, currentAtTerm} = 2'h3;
    cyc(4);
    chkb("chargeDone", 1'b1, chargeDone);
    chkb("pwmOn", 1'b0, pwmOn);
    {batAtFloat, currentAtTerm, batBelowRecharge} = 3'h1;
    cyc(3);
    chkb("chargeDone", 1'b0, chargeDone);
    chkb("chargerOn", 1'b1, chargerOn);
    batBelowRecharge = 1'b0;
    // A start request while blocked must be dropped, not held over.
    chargeInhibit = 1'b1;
    host_model_inst.write_reg(3'h2, 8'h00);
    cyc(3);
    chkb("chargerOn", 1'b0, chargerOn);
    chargeInhibit = 1'b0;
    disable_input = 1'b1;
    host_model_inst.write_reg(3'h2, 8'h00);
    cyc(3);
    chkb("chargerOn", 1'b0, chargerOn);
    disable_input = 1'b0;
    cyc(3);
    chkb("chargerOn", 1'b0, chargerOn);
    foreach (codes[i]) begin
      host_model_inst.write_reg(3'h2, {codes[i], 2'b00});
      cyc(3);
      chkv("float_voltage", floatExp(codes[i]), float_voltage);
      rdchk(3'h2, {codes[i], 2'b00});
      chkb("chargerOn", 1'b1, chargerOn);
    end
    {batAtFloat, currentAtTerm} = 2'h3;
    host_model_inst.write_reg(3'h1, 8'hF0);
    cyc(20);
    chkb("chargeDone", 1'b0, chargeDone);
    chkb("chargerOn", 1'b1, chargerOn);
    chkb("termEnable", 1'b0, termination_enable);
    chkv("inputLimit", 13'h0003, {11'h000, input_current_limit_code});
    chkv("weakThreshold", 13'h0003, {11'h000, weak_battery_threshold});
    host_model_inst.write_reg(3'h4, 8'h7D);
    cyc(3);
    chkv("termCurrent", 13'h0005, {10'h000, termination_current});
    rdchk(3'h4, 8'h7D);
    // Host watchdog is 32 ticks of 10 cycles; expiry restores defaults.
    cyc(295);
    chkb("termEnable", 1'b0, termination_enable);
    cyc(45);
    chkb("termEnable", 1'b1, termination_enable);
    rdchk(3'h1, 8'h08);
    // Unattended charging with no host writes must time out into a fault.
    {currentAtTerm, batBelowRecharge} = 2'h1;
    cyc(1);
    batBelowRecharge = 1'b0;
    cyc(8950);
    chkb("timerFault", 1'b0, timerFault);
    cyc(100);
    chkb("timerFault", 1'b1, timerFault);
    chkb("chargerOn", 1'b0, chargerOn);
    {boostRequest, high_impedance_request} = 2'h3;
    cyc(3);
    chkb("pathBlocked", 1'b1, pathBlocked);
    chkb("chargerOn", 1'b0, chargerOn);
    chkb("boostOn", 1'b0, boostOn);
    high_impedance_request = 1'b0;
    cyc(3);
    chkb("pathBlocked", 1'b0, pathBlocked);
    chkb("boostOn", 1'b1, boostOn);
    {boostRequest, prodTestRequest} = 2'h1;
    cyc(3);
    chkv("float_voltage", 13'h1068, float_voltage);
    chkv("testLoad", 13'h08FC, {1'b0, testLoadLimitMa});
    chkb("pwmOn", 1'b1, pwmOn);
    prodTestRequest = 1'b0;
    cyc(3);
    chkv("testLoad", 13'h0000, {1'b0, testLoadLimitMa});
    results();
  end
endmodule // charger_mode_control_tb
`default_nettype wire
